// ### inc/uart_tfc_pkg.sv
// Constants for the timer, flow-control and interrupt-gating slice of the UART
package uart_tfc_pkg;
  // ==========================================================
  // Register addresses (4-bit register port)
  localparam logic [3:0] ADDR_MODE_ONE = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CLK_SEL = 4'h1;
  localparam logic [3:0] ADDR_RATE_TOGGLE = 4'h2;
  localparam logic [3:0] ADDR_COMMAND = 4'h2;
  localparam logic [3:0] ADDR_TX_HOLD = 4'h3;
  localparam logic [3:0] ADDR_AUX_CTRL = 4'h4;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h5;
  localparam logic [3:0] ADDR_INT_MASK = 4'h5;
  localparam logic [3:0] ADDR_PRESET_HI = 4'h6;
  localparam logic [3:0] ADDR_PRESET_LO = 4'h7;
  localparam logic [3:0] ADDR_MODE_TWO = 4'h8;
  localparam logic [3:0] ADDR_RATE_INFO = 4'h9;
  // ==========================================================
  // Field positions
  localparam int MR1_RX_FLOW_BIT = 7;
  localparam int MR2_CTS_EN_BIT = 4;
  localparam int IMR_MPI_BIT = 6;
  localparam int ISR_CT_READY_BIT = 4;
  localparam int ISR_TX_EMPTY_BIT = 1;
  localparam int ISR_TX_READY_BIT = 0;
  localparam int ACR_RATE_SET_BIT = 7;
  localparam int ACR_CT_MODE_MSB = 6;
  localparam int ACR_CT_MODE_LSB = 4;
  localparam int ACR_OUT_SEL_MSB = 2;
  localparam int ACR_OUT_SEL_LSB = 0;
  localparam int MR1_WAKE_MSB = 4;
  localparam int MR1_WAKE_LSB = 3;
  // ==========================================================
  // Command codes in the upper nibble, enable/disable bit positions in the lower nibble of the command register
  localparam logic [3:0] CMD_RX_RESET = 4'h4;
  localparam logic [3:0] CMD_START_CT = 4'h8;
  localparam logic [3:0] CMD_STOP_CT = 4'h9;
  localparam logic [3:0] CMD_OUT_SET = 4'hA;
  localparam logic [3:0] CMD_OUT_CLR = 4'hB;
  localparam int CMD_TX_EN_BIT = 2;
  localparam int CMD_TX_DIS_BIT = 3;
  localparam int CMD_RX_EN_BIT = 0;
  // ==========================================================
  // Output select and rate codes
  localparam logic [2:0] OSEL_RTS = 3'h0;
  localparam logic [2:0] OSEL_CT = 3'h1;
  localparam logic [3:0] RATE_TIMER = 4'hD;
  localparam logic [3:0] RATE_EXT16 = 4'hE;
  localparam logic [3:0] RATE_EXT1 = 4'hF;
  localparam logic [1:0] WAKE_MODE = 2'h3;
  // ==========================================================
  // Reset values and timing
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] PRESET_RESET = 16'h0002;
  localparam int BIT_TICKS_16X = 16;
  localparam int DISABLE_WIN_16X = 3;
  localparam int RX_FIFO_DEPTH = 3;
  localparam logic [4:0] PERIOD_RESET = 5'h10;
endpackage : uart_tfc_pkg

// ### hw/uart_timer_flow_ctrl.sv
// Timer, flow control, rate select and interrupt gating of the UART
`timescale 1ns/10ps
// Function
// RULE_01: Masked status bits drive low interrupt output
// RULE_02: Mask bit six plus high input interrupts
// RULE_03: Software loads preset bytes, never below two
// RULE_04: Timer square wave period twice preset
// RULE_05: Preset change waits for next half-period
// RULE_06: Timer ready once per cycle; stop clears
// RULE_07: Counter starts on command, runs past zero
// RULE_08: Counter output high until terminal, stop restores
// RULE_09: New preset used only at start
// RULE_10: Clear-to-send high halts after current character
// RULE_11: Full FIFO plus fourth start raises request
// RULE_12: Commands 1010/1011 set and clear output bit
// RULE_13: Output pin is NAND of bit and flow
// RULE_14: Flow control off restores plain output bit
// RULE_15: Early disable after load sends nothing
// RULE_16: Underrun load then disable discards character
// RULE_17: Transmit empty set when underrun or enabled
// RULE_18: Hold moved in start bit; ready after
// RULE_19: Clock select table, 1101 timer, external codes
// RULE_20: Read of address two toggles test rates
// RULE_21: Receiver reset keeps all programming intact
// RULE_22: Software leaves wake-up before receiver reset
// RULE_23: Output select 000 request, 001 timer
// RULE_24: Timer reloads and toggles at each zero
module uart_timer_flow_ctrl
  import uart_tfc_pkg::*;
(
  input wire logic CORE_CLK_I, // 250 MHz core clock
  input wire logic RESET_N_I, // Async reset, active low
  input wire logic [3:0] ADDR_I, // Register address
  input wire logic [7:0] WDATA_I, // Write data
  input wire logic WR_I, // Write strobe
  input wire logic RD_I, // Read strobe
  output logic [7:0] RDATA_O, // Read data, next cycle
  input wire logic MPI_PIN_I, // Multipurpose input, clear_to_send_n
  input wire logic CT_CLK_I, // Selected counter/timer clock pin
  input wire logic TX_TICK_I, // 16x transmit tick from datapath
  input wire logic TX_CHAR_DONE_I, // Last stop bit shifted out
  input wire logic RX_START_I, // Receiver start bit detected
  input wire logic RX_FIFO_FULL_I, // Receive FIFO holds three
  output logic IRQ_OUT_N_O, // Interrupt, active low
  output logic MPO_PIN_O, // Multipurpose output pin
  output logic TX_LOAD_O, // Pulse: move hold to shift reg
  output logic TX_HALT_O, // Transmitter held by flow control
  output logic RX_RESET_O, // Pulse: receiver reset
  output logic [3:0] RX_RATE_O, // Receiver rate code
  output logic [3:0] TX_RATE_O, // Transmitter rate code
  output logic RATE_TEST_O, // Extended rate table active
  output logic RATE_SET_O // Rate set bit
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [2:0] mpi_sync;
    logic mpi_level;
    logic [2:0] ctc_sync;
    logic ctc_level;
    logic [7:0] mode_one;
    logic [7:0] mode_two;
    logic [7:0] clk_sel;
    logic [7:0] aux_ctrl;
    logic [7:0] int_mask;
    logic [7:0] preset_hi;
    logic [7:0] preset_lo;
    logic [15:0] count;
    logic ct_running;
    logic ct_ready;
    logic ct_wave;
    logic ct_half;
    logic out_bit;
    logic rts_flow;
    logic rate_test;
    logic tx_enabled;
    logic tx_hold_full;
    logic tx_in_char;
    logic tx_ready;
    logic tx_empty;
    logic [4:0] tx_ticks;
    logic tx_load;
    logic rx_reset;
    logic [7:0] rdata;
  } state_t;

  state_t q, d;

  logic mpi_high;
  logic ct_edge;
  logic [7:0] int_status;
  logic ct_zero;
  logic ct_set;

  function automatic logic [15:0] preset_of(input state_t s);
    preset_of = {s.preset_hi, s.preset_lo};
  endfunction : preset_of

  function automatic logic timer_mode(input state_t s);
    timer_mode = s.aux_ctrl[ACR_CT_MODE_MSB];
  endfunction : timer_mode

  assign mpi_high = q.mpi_level;
  assign ct_zero = (q.count == 16'h0001) || (q.count == 16'h0000);

  always_comb begin
    int_status = 8'h00;
    int_status[IMR_MPI_BIT] = mpi_high;
    int_status[ISR_CT_READY_BIT] = q.ct_ready;
    int_status[ISR_TX_EMPTY_BIT] = q.tx_empty;
    int_status[ISR_TX_READY_BIT] = q.tx_ready;
  end

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    ct_set = 1'b0;
    // Two-flop release so every register leaves reset on one edge
    d.rst_sync = {q.rst_sync[0], 1'b1};
    d.mpi_sync = {q.mpi_sync[1:0], MPI_PIN_I};
    // A change counts only once two stages agree, so a runt is lost
    if (q.mpi_sync[2] == q.mpi_sync[1]) begin
      d.mpi_level = q.mpi_sync[2];
    end
    d.ctc_sync = {q.ctc_sync[1:0], CT_CLK_I};
    if (q.ctc_sync[2] == q.ctc_sync[1]) begin
      d.ctc_level = q.ctc_sync[2];
    end
    ct_edge = d.ctc_level && !q.ctc_level;
    d.tx_load = 1'b0;
    d.rx_reset = 1'b0;
    d.rdata = 8'h00;

    // Counter/timer
    if (ct_edge) begin
      if (timer_mode(q)) begin
        // RULE_24: auto reload
        if (ct_zero) begin
          // RULE_05: new preset only at boundary
          d.count = preset_of(q);
          // RULE_04: toggle each half
          d.ct_wave = !q.ct_wave;
          d.ct_half = !q.ct_half;
          // RULE_06: once per full cycle
          if (q.ct_half) begin
            d.ct_ready = 1'b1;
            ct_set = 1'b1;
          end
        end else begin
          d.count = q.count - 16'h0001;
        end
      end else if (q.ct_running) begin
        // RULE_07: keeps counting past terminal
        d.count = q.count - 16'h0001;
        if (q.count == 16'h0001) begin
          d.ct_ready = 1'b1;
          ct_set = 1'b1;
          // RULE_08: low at terminal count
          d.ct_wave = 1'b0;
        end
      end
    end

    // RULE_11: flow control raises request
    // Request drops only once the FIFO has room again
    if (q.mode_one[MR1_RX_FLOW_BIT] && RX_FIFO_FULL_I && RX_START_I) begin
      d.rts_flow = 1'b1;
    end else if (!RX_FIFO_FULL_I) begin
      d.rts_flow = 1'b0;
    end

    // Transmitter timing
    // Halt gates only the next start; a char in flight runs out
    if (TX_TICK_I && q.tx_enabled) begin
      if (q.tx_hold_full && !q.tx_in_char && !TX_HALT_O) begin
        d.tx_in_char = 1'b1;
        d.tx_ticks = 5'h00;
        d.tx_empty = 1'b0;
      end else if (q.tx_in_char && q.tx_ticks != PERIOD_RESET) begin
        d.tx_ticks = q.tx_ticks + 5'h01;
        // RULE_18: transfer in start bit
        if (q.tx_ticks == 5'(DISABLE_WIN_16X - 1)) begin
          d.tx_load = 1'b1;
          d.tx_hold_full = 1'b0;
        end
        if (q.tx_ticks == 5'(BIT_TICKS_16X - 1)) begin
          d.tx_ready = 1'b1;
        end
      end
    end
    if (TX_CHAR_DONE_I) begin
      d.tx_in_char = 1'b0;
      // RULE_17: underrun shows empty
      d.tx_empty = !q.tx_hold_full;
    end

    // Register writes
    if (WR_I) begin
      unique case (ADDR_I)
        ADDR_MODE_ONE: d.mode_one = WDATA_I;
        ADDR_MODE_TWO: d.mode_two = WDATA_I;
        ADDR_CLK_SEL: d.clk_sel = WDATA_I;
        ADDR_AUX_CTRL: d.aux_ctrl = WDATA_I;
        ADDR_INT_MASK: d.int_mask = WDATA_I;
        // RULE_09: stored only; loaded at start
        ADDR_PRESET_HI: d.preset_hi = WDATA_I;
        ADDR_PRESET_LO: d.preset_lo = WDATA_I;
        ADDR_TX_HOLD: begin
          d.tx_hold_full = 1'b1;
          d.tx_ready = 1'b0;
        end
        ADDR_COMMAND: begin
          if (WDATA_I[CMD_TX_EN_BIT]) begin
            d.tx_enabled = 1'b1;
            // RULE_17: set on enable
            d.tx_empty = !q.tx_in_char;
            d.tx_ready = !q.tx_hold_full;
          end
          if (WDATA_I[CMD_TX_DIS_BIT]) begin
            d.tx_enabled = 1'b0;
            // RULE_15: early disable drops char
            // RULE_16: underrun load discarded
            // Past the load window the char in flight is already committed
            if (q.tx_hold_full && !d.tx_load) begin
              d.tx_hold_full = 1'b0;
              d.tx_in_char = q.tx_in_char && q.tx_ticks >= 5'(DISABLE_WIN_16X);
              d.tx_ready = 1'b1;
              d.tx_empty = !d.tx_in_char;
            end
          end
          unique case (WDATA_I[7:4])
            // RULE_21: only receiver state resets
            CMD_RX_RESET: d.rx_reset = 1'b1;
            CMD_START_CT: begin
              d.ct_running = 1'b1;
              d.count = preset_of(q);
              d.ct_wave = 1'b1;
              d.ct_ready = 1'b0;
            end
            // RULE_06: stop clears flag
            // RULE_08: stop restores output
            CMD_STOP_CT: begin
              d.ct_running = 1'b0;
              // A count event in the same cycle wins over the stop
              d.ct_ready = ct_set;
              if (!timer_mode(q)) begin
                d.ct_wave = 1'b1;
              end
            end
            // RULE_12: output bit commands
            CMD_OUT_SET: d.out_bit = 1'b1;
            CMD_OUT_CLR: d.out_bit = 1'b0;
            default: ;
          endcase
        end
        default: ;
      endcase
    end

    // Register reads
    if (RD_I) begin
      unique case (ADDR_I)
        ADDR_MODE_ONE: d.rdata = q.mode_one;
        ADDR_STATUS: d.rdata = {4'h0, q.tx_empty, q.tx_ready, 2'b00};
        // RULE_20: read toggles rate table
        ADDR_RATE_TOGGLE: begin
          d.rate_test = !q.rate_test;
          d.rdata = 8'h00;
        end
        // RULE_01: unmasked status read
        ADDR_INT_STATUS: d.rdata = int_status;
        // Live count, so software can poll progress
        ADDR_PRESET_HI: d.rdata = q.count[15:8];
        ADDR_PRESET_LO: d.rdata = q.count[7:0];
        ADDR_MODE_TWO: d.rdata = q.mode_two;
        ADDR_RATE_INFO: d.rdata = {6'h00, q.rate_test, q.aux_ctrl[7]};
        default: d.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      q <= '0;
      q.preset_hi <= PRESET_RESET[15:8];
      q.preset_lo <= PRESET_RESET[7:0];
      q.ct_wave <= 1'b1;
      q.mpi_sync <= 3'b111;
      q.mpi_level <= 1'b1;
      q.tx_ready <= 1'b1;
      q.tx_empty <= 1'b1;
    end else if (!q.rst_sync[1]) begin
      q <= '0;
      q.rst_sync <= d.rst_sync;
      q.preset_hi <= PRESET_RESET[15:8];
      q.preset_lo <= PRESET_RESET[7:0];
      q.ct_wave <= 1'b1;
      q.mpi_sync <= 3'b111;
      q.mpi_level <= 1'b1;
      q.tx_ready <= 1'b1;
      q.tx_empty <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  logic flow_en;
  logic rts_n;
  assign flow_en = q.mode_one[MR1_RX_FLOW_BIT];
  // RULE_13: NAND of bit and flow signal
  // RULE_14: flow off leaves bit only
  assign rts_n = flow_en ? !(q.out_bit && !q.rts_flow) : !q.out_bit;

  always_comb begin
    // RULE_23: output select
    unique case (q.aux_ctrl[ACR_OUT_SEL_MSB:ACR_OUT_SEL_LSB])
      OSEL_RTS: MPO_PIN_O = rts_n;
      OSEL_CT: MPO_PIN_O = q.ct_wave;
      default: MPO_PIN_O = rts_n;
    endcase
  end

  // RULE_01: masked status gates interrupt
  // RULE_02: mpi bit is level high
  assign IRQ_OUT_N_O = !(|(int_status & q.int_mask));
  // RULE_10: clear-to-send gating
  assign TX_HALT_O = q.mode_two[MR2_CTS_EN_BIT] && mpi_high;
  assign RDATA_O = q.rdata;
  assign TX_LOAD_O = q.tx_load;
  assign RX_RESET_O = q.rx_reset;
  // RULE_19: codes go to rate generator
  assign RX_RATE_O = q.clk_sel[7:4];
  assign TX_RATE_O = q.clk_sel[3:0];
  assign RATE_TEST_O = q.rate_test;
  assign RATE_SET_O = q.aux_ctrl[ACR_RATE_SET_BIT];

endmodule : uart_timer_flow_ctrl

// ### dv/uart_tfc_remote.sv
// Far-side serial device: flow lines, ticks and counter clock
`timescale 1ns/10ps
module uart_tfc_remote (
  input wire logic clk_i, // Core clock
  input wire logic busy_i, // Remote cannot take data
  input wire logic send_i, // Remote starts a character
  input wire logic full_i, // Receive FIFO full level
  input wire logic load_i, // Hold moved to shift register
  output logic cts_n_o, // Clear to send, low active
  output logic ct_clk_o, // Counter clock, 8 cycles
  output logic tick_o, // 16x tick, every 4 cycles
  output logic done_o, // Character end after a load
  output logic start_o, // Start bit seen
  output logic full_o // FIFO full
);
  logic [7:0] div_q = 8'h00;
  logic [9:0] char_q = 10'h000;
  always_ff @(posedge clk_i) begin
    div_q <= div_q + 8'h01;
  end
  // Character ends a fixed time after its load, never mid start bit
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      char_q <= 10'h001;
    end else if (char_q != 10'h000) begin
      char_q <= char_q + 10'h001;
    end
  end
  assign cts_n_o = busy_i;
  assign ct_clk_o = div_q[2];
  assign tick_o = div_q[1:0] == 2'h0;
  assign done_o = char_q == 10'h258;
  assign start_o = send_i;
  assign full_o = full_i;
endmodule : uart_tfc_remote

// ### dv/uart_tfc_properties.sv
// Checker for rate select, receiver reset and send gating
`timescale 1ns/10ps
module uart_tfc_props
  import uart_tfc_pkg::*;
(
  input wire logic CORE_CLK_I, // Clock
  input wire logic RESET_N_I, // Reset
  input wire logic [3:0] ADDR_I, // Address
  input wire logic [7:0] WDATA_I, // Write data
  input wire logic WR_I, // Write
  input wire logic RD_I, // Read
  input wire logic [7:0] RDATA_O, // Read data
  input wire logic TX_HALT_O, // Halt
  input wire logic RX_RESET_O, // Rx reset
  input wire logic [3:0] RX_RATE_O, // Rx rate
  input wire logic [3:0] TX_RATE_O, // Tx rate
  input wire logic RATE_TEST_O, // Test table
  input wire logic RATE_SET_O // Rate set
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  logic cts_en_q;
  wire tog_rd = RD_I && ADDR_I == ADDR_RATE_TOGGLE;
  wire info_rd = RD_I && ADDR_I == ADDR_RATE_INFO;
  wire rx_cmd = WR_I && ADDR_I == ADDR_COMMAND
    && WDATA_I[7:4] == CMD_RX_RESET;
  // Shadow of the send gate enable
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cts_en_q <= 1'b0;
    end else if (WR_I && ADDR_I == ADDR_MODE_TWO) begin
      cts_en_q <= WDATA_I[MR2_CTS_EN_BIT];
    end
  end
  sequence s_csr;
    (WR_I && ADDR_I == ADDR_CLK_SEL)
      ##1 ({RX_RATE_O, TX_RATE_O} == $past(WDATA_I));
  endsequence
  // ==========
  // Properties
  AST_RATE_TOGGLE:
    assert property (tog_rd |=> RATE_TEST_O != $past(RATE_TEST_O))
    else $error("rate test kept");
  AST_RATE_HOLD:
    assert property (!tog_rd |=> $stable(RATE_TEST_O))
    else $error("rate test moved");
  AST_RATE_INFO:
    assert property (info_rd |=>
      RDATA_O == {6'h00, $past(RATE_TEST_O), $past(RATE_SET_O)})
    else $error("rate info wrong");
  AST_CLK_SEL:
    assert property (WR_I && ADDR_I == ADDR_CLK_SEL |-> s_csr)
    else $error("rate codes wrong");
  AST_RX_RST_PULSE:
    assert property (rx_cmd |=> RX_RESET_O)
    else $error("no rx reset");
  AST_RX_RST_CAUSE:
    assert property (RX_RESET_O |-> $past(rx_cmd))
    else $error("stray rx reset");
  AST_RX_RST_KEEP:
    assert property (RX_RESET_O |-> $stable(RX_RATE_O) && $stable(TX_RATE_O))
    else $error("rx reset lost rates");
  AST_CTS_OFF:
    assert property (!cts_en_q |-> !TX_HALT_O)
    else $error("halt without gate");
endmodule : uart_tfc_props
bind uart_timer_flow_ctrl uart_tfc_props u_props (
  .CORE_CLK_I(CORE_CLK_I),
  .RESET_N_I(RESET_N_I),
  .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I),
  .WR_I(WR_I),
  .RD_I(RD_I),
  .RDATA_O(RDATA_O),
  .TX_HALT_O(TX_HALT_O),
  .RX_RESET_O(RX_RESET_O),
  .RX_RATE_O(RX_RATE_O),
  .TX_RATE_O(TX_RATE_O),
  .RATE_TEST_O(RATE_TEST_O),
  .RATE_SET_O(RATE_SET_O)
);

// ### dv/test_uart_timer_flow_ctrl.sv
// Self-checking bench for the timer and flow-control slice
`timescale 1ns/10ps
module test_uart_timer_flow_ctrl;
  import uart_tfc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic busy = 1'b0, send = 1'b0, full = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, d, rdata;
  logic multipurpose_input, ctclk, tick, done, start, fullo, irq_n, multipurpose_output, load, halt;
  logic rxrst, rtest, rset;
  logic [3:0] rxr, txr;
  int failures = 0, checks = 0, loads = 0, rsts = 0, c;
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    loads += int'(load === 1'b1);
    rsts += int'(rxrst === 1'b1);
  end
  uart_timer_flow_ctrl dut (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .MPI_PIN_I(multipurpose_input),
    .CT_CLK_I(ctclk), .TX_TICK_I(tick), .TX_CHAR_DONE_I(done),
    .RX_START_I(start), .RX_FIFO_FULL_I(fullo), .IRQ_OUT_N_O(irq_n),
    .MPO_PIN_O(multipurpose_output), .TX_LOAD_O(load), .TX_HALT_O(halt),
    .RX_RESET_O(rxrst), .RX_RATE_O(rxr), .TX_RATE_O(txr),
    .RATE_TEST_O(rtest), .RATE_SET_O(rset));
  uart_tfc_remote remote (
    .clk_i(clk), .busy_i(busy), .send_i(send), .full_i(full),
    .load_i(load),
    .cts_n_o(multipurpose_input), .ct_clk_o(ctclk), .tick_o(tick), .done_o(done),
    .start_o(start), .full_o(fullo));
  // ==========
  // Helpers
  function automatic logic [7:0] b(logic x);
    return {7'h00, x};
  endfunction : b
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : cyc
  // Strobes drop for one cycle so back-to-back calls never collide
  task automatic wr_reg(logic [3:0] a, logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask : wr_reg
  task automatic rd_reg(logic [3:0] a);
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    d = rdata;
    cyc(1);
  endtask : rd_reg
  // Bounded wait on {mpo, halt, irq_n}; c gets the cycles spent
  task automatic await(logic [2:0] m, logic [2:0] want, int lim);
    c = 0;
    while ((({multipurpose_output, halt, irq_n} & m) !== want) && c < lim) begin
      cyc(1);
      c++;
    end
  endtask : await
  // ==========
  // Scenarios
  task automatic t_rates();
    wr_reg(ADDR_CLK_SEL, {RATE_TIMER, RATE_EXT16});
    chk("rates", {RATE_TIMER, RATE_EXT16}, {rxr, txr});
    wr_reg(ADDR_CLK_SEL, {RATE_EXT1, RATE_EXT1});
    chk("rates", {RATE_EXT1, RATE_EXT1}, {rxr, txr});
    wr_reg(ADDR_AUX_CTRL, 8'h80);
    chk("rate set", 8'h01, b(rset));
    for (int i = 0; i < 2; i++) begin
      rd_reg(ADDR_RATE_TOGGLE);
      rd_reg(ADDR_RATE_INFO);
      chk("rate info", {6'h00, !i[0], 1'b1}, d);
    end
  endtask : t_rates
  task automatic t_mpo();
    wr_reg(ADDR_AUX_CTRL, 8'h00);
    wr_reg(ADDR_COMMAND, {CMD_OUT_CLR, 4'h0});
    chk("mpo clear", 8'h01, b(multipurpose_output));
    wr_reg(ADDR_COMMAND, {CMD_OUT_SET, 4'h0});
    chk("mpo set", 8'h00, b(multipurpose_output));
    wr_reg(ADDR_MODE_ONE, 8'h80);
    chk("mpo flow on", 8'h00, b(multipurpose_output));
    full <= 1'b1;
    send <= 1'b1;
    cyc(1);
    send <= 1'b0;
    await(3'b100, 3'b100, 8);
    chk("mpo request", 8'h01, b(multipurpose_output));
    wr_reg(ADDR_MODE_ONE, 8'h00);
    chk("mpo flow off", 8'h00, b(multipurpose_output));
    full <= 1'b0;
  endtask : t_mpo
  task automatic t_irq();
    wr_reg(ADDR_INT_MASK, 8'h00);
    busy <= 1'b1;
    cyc(6);
    rd_reg(ADDR_INT_STATUS);
    chk("mpi status", 8'h40, d & 8'h40);
    chk("irq masked", 8'h01, b(irq_n));
    wr_reg(ADDR_INT_MASK, 8'h40);
    chk("irq mpi", 8'h00, b(irq_n));
    busy <= 1'b0;
    await(3'b001, 3'b001, 8);
    chk("irq off", 8'h01, b(irq_n));
    wr_reg(ADDR_INT_MASK, 8'h00);
  endtask : t_irq
  task automatic t_cts();
    wr_reg(ADDR_MODE_TWO, 8'h10);
    rd_reg(ADDR_MODE_TWO);
    chk("mode two", 8'h10, d);
    busy <= 1'b1;
    await(3'b010, 3'b010, 300);
    chk("halt", 8'h01, b(halt));
    busy <= 1'b0;
    await(3'b010, 3'b000, 8);
    chk("resume", 8'h00, b(halt));
    wr_reg(ADDR_MODE_TWO, 8'h00);
    busy <= 1'b1;
    cyc(300);
    chk("gate off", 8'h00, b(halt));
    busy <= 1'b0;
  endtask : t_cts
  task automatic t_timer();
    wr_reg(ADDR_PRESET_HI, 8'h00);
    wr_reg(ADDR_PRESET_LO, 8'h04);
    wr_reg(ADDR_AUX_CTRL, 8'h41);
    await(3'b100, 3'b000, 200);
    await(3'b100, 3'b100, 200);
    await(3'b100, 3'b000, 200);
    chk("half period", 8'h20, c[7:0]);
    wr_reg(ADDR_PRESET_LO, 8'h06);
    await(3'b100, 3'b100, 200);
    chk("old half", 8'h20, c[7:0] + 8'h02);
    await(3'b100, 3'b000, 200);
    chk("new half", 8'h30, c[7:0]);
    rd_reg(ADDR_INT_STATUS);
    chk("ready", 8'h10, d & 8'h10);
    wr_reg(ADDR_COMMAND, {CMD_STOP_CT, 4'h0});
    rd_reg(ADDR_INT_STATUS);
    chk("ready clear", 8'h00, d & 8'h10);
    await(3'b100, 3'b100, 200);
    chk("wave runs", 8'h30, c[7:0] + 8'h06);
  endtask : t_timer
  task automatic t_counter();
    wr_reg(ADDR_AUX_CTRL, 8'h01);
    wr_reg(ADDR_COMMAND, {CMD_STOP_CT, 4'h0});
    chk("ct idle", 8'h01, b(multipurpose_output));
    wr_reg(ADDR_PRESET_LO, 8'h03);
    // Second pass reuses the preset without a rewrite
    for (int i = 0; i < 2; i++) begin
      wr_reg(ADDR_COMMAND, {CMD_START_CT, 4'h0});
      await(3'b100, 3'b000, 100);
      chk("ct count", 8'h01, b(c >= 12 && c <= 34));
      cyc(40);
      rd_reg(ADDR_INT_STATUS);
      chk("ct past end", 8'h10, (d & 8'h10) | b(multipurpose_output));
      wr_reg(ADDR_COMMAND, {CMD_STOP_CT, 4'h0});
      rd_reg(ADDR_INT_STATUS);
      chk("ct stop", 8'h01, (d & 8'h10) | b(multipurpose_output));
    end
  endtask : t_counter
  task automatic t_rx();
    wr_reg(ADDR_MODE_ONE, 8'h18);
    wr_reg(ADDR_MODE_ONE, 8'h08);
    wr_reg(ADDR_COMMAND, {CMD_RX_RESET, 4'h0});
    wr_reg(ADDR_COMMAND, 8'h01);
    wr_reg(ADDR_MODE_ONE, 8'h18);
    rd_reg(ADDR_MODE_ONE);
    chk("mode kept", 8'h18, d);
    chk("rx resets", 8'h01, rsts[7:0]);
    chk("rates kept", {RATE_EXT1, RATE_EXT1}, {rxr, txr});
  endtask : t_rx
  task automatic t_tx();
    int l0;
    wr_reg(ADDR_COMMAND, 8'h04);
    rd_reg(ADDR_STATUS);
    chk("tx empty", 8'h08, d & 8'h08);
    l0 = loads;
    wr_reg(ADDR_TX_HOLD, 8'h55);
    wr_reg(ADDR_COMMAND, 8'h08);
    cyc(100);
    chk("early off", 8'h00, 8'(loads - l0));
    wr_reg(ADDR_COMMAND, 8'h04);
    wr_reg(ADDR_TX_HOLD, 8'hAA);
    cyc(100);
    rd_reg(ADDR_STATUS);
    chk("load ready", 8'h05, 8'(loads - l0) | (d & 8'h04));
  endtask : t_tx
  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    t_rates();
    t_mpo();
    t_irq();
    t_cts();
    t_timer();
    t_counter();
    t_rx();
    t_tx();
    end_sim();
  end
endmodule : test_uart_timer_flow_ctrl
